// *** logic/rvm_pkg.sv ***
// Package of constants and carrier types for the reset and interrupt vector map
package rvm_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int          RVM_ADDR_W     = 17;    // Word address into program memory
    localparam int          RVM_NUM_W      = 5;     // Vector number 1..31
    localparam int          RVM_NUM_VEC    = 31;    // Reset plus thirty interrupt sources
    localparam int          RVM_NUM_IRQ    = 30;    // Interrupt sources only
    localparam int          RVM_WIN_W      = 3;
    localparam logic [2:0]  RVM_CE_WINDOW  = 3'h4;  // Cycles the change window stays open
    localparam logic [4:0]  RVM_FIRST_IRQ  = 5'h02; // Vector number of interrupt source 0
    localparam logic [4:0]  RVM_VEC_STEP   = 5'h02; // Words between two vectors

    // ------------------------------------------------------------------
    // Reset values and fuse decoding
    // ------------------------------------------------------------------
    localparam logic        RVM_FUSE_UNPROG = 1'b1; // Fuse reads one when unprogrammed
    localparam logic        RVM_SEL_RST     = 1'b0; // Table starts in application space
    localparam logic [16:0] RVM_APP_START   = 17'h00000;

    // ------------------------------------------------------------------
    // Base vector table, indexed by vector number minus one
    // ------------------------------------------------------------------
    localparam logic [15:0] RVM_VEC_TAB [RVM_NUM_VEC] = '{
        16'h0000,                                  // Reset
        16'h0002, 16'h0004, 16'h0006,              // External requests 0..2
        16'h0008, 16'h000A, 16'h000C, 16'h000E,    // Pin change 0..3
        16'h0010,                                  // Watchdog time-out
        16'h0012, 16'h0014, 16'h0016,              // Second 8-bit timer
        16'h0018, 16'h001A, 16'h001C, 16'h001E,    // 16-bit timer
        16'h0020, 16'h0022, 16'h0024,              // First 8-bit timer
        16'h0026,                                  // Serial peripheral transfer done
        16'h0028, 16'h002A, 16'h002C,              // First serial port
        16'h002E, 16'h0030, 16'h0032, 16'h0034, 16'h0036, // Comparator to store ready
        16'h0038, 16'h003A, 16'h003C               // Second serial port
    };

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    // Write of the two vector control bits by the core
    typedef struct packed {
        logic wr;
        logic change_enable;
        logic table_select;
    } rvm_ctl_wr_t;

    // Vector presented to the core
    typedef struct packed {
        logic                  valid;
        logic [RVM_NUM_W-1:0]  num;
        logic [RVM_ADDR_W-1:0] addr;
    } rvm_vec_t;

    // Protection of the select bit
    typedef enum logic [1:0] {
        RVM_BLK_IDLE,
        RVM_BLK_ARMED,
        RVM_BLK_AFTER_WR
    } rvm_blk_t;

    // Whole state of the vector map
    typedef struct packed {
        logic                  fuse_m_r;
        logic                  fuse_s_r;
        logic [RVM_ADDR_W-1:0] boot_m_r;
        logic [RVM_ADDR_W-1:0] boot_s_r;
        logic                  sel_r;
        logic                  ce_r;
        logic [RVM_WIN_W-1:0]  win_r;
        rvm_blk_t              blk_r;
        logic                  blocked_r;
        logic [RVM_ADDR_W-1:0] rst_addr_r;
        rvm_vec_t              vec_r;
    } rvm_state_t;

endpackage : rvm_pkg

// *** logic/rvm_prio_enc.sv ***
// Lowest-index-first priority encoder for pending interrupt sources
`timescale 1ns/100ps
`default_nettype none

module rvm_prio_enc #(
    parameter int N  = 30,
    parameter int IW = 5
) (
    // Requests
    input  wire logic [N-1:0]  i_req,
    // Result
    output logic               o_found,
    output logic [IW-1:0]      o_idx
);

    // ------------------------------------------------------------------
    // Scan from the top so the lowest set bit is the last to win
    // ------------------------------------------------------------------
    always_comb begin
        o_found = 1'b0;
        o_idx   = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (i_req[k]) begin
                o_found = 1'b1;
                o_idx   = IW'(k);
            end
        end
    end

endmodule : rvm_prio_enc

`default_nettype wire

// *** logic/rvm_vector_map.sv ***
// Reset and interrupt vector address generation with table relocation
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Every reset cause starts at address 0x0000 unless the boot fuse relocates it.
// - External requests 0..2 use vectors 2..4 at 0x0002, 0x0004, 0x0006.
// - Pin change 0..3 use 0x0008..0x000E; watchdog time-out uses 0x0010.
// - Second 8-bit timer compare A, B, overflow use 0x0012, 0x0014, 0x0016.
// - 16-bit timer capture, compare A, B, overflow use 0x0018..0x001E.
// - First 8-bit timer compare A, B, overflow use 0x0020, 0x0022, 0x0024.
// - Serial peripheral transfer complete uses vector 20 at 0x0026.
// - First serial port receive, empty, transmit use 0x0028, 0x002A, 0x002C.
// - Comparator, converter, EEPROM, two-wire, store ready use 0x002E..0x0036.
// - Second serial port uses 0x0038, 0x003A, 0x003C, the last of 31.
// - Programmed boot fuse makes reset start at the boot loader address.
// - Select bit set adds the boot section start to each interrupt vector address.
// - Reset address and interrupt table start are chosen independently.
// - Fuse value one means application start, zero means boot section.
// - Consecutive vectors lie two words apart.
// - Select changes only by write with change-enable cleared within four cycles.
// - Interrupts blocked from change-enable until after next instruction, or four cycles.

module rvm_vector_map (
    // Clock and reset
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_rst,
    // Fuse straps from the nonvolatile array
    input  wire logic                        i_boot_reset_fuse,
    input  wire logic [rvm_pkg::RVM_ADDR_W-1:0] i_boot_start_addr,
    // Core side: control bit writes and instruction retire
    input  wire rvm_pkg::rvm_ctl_wr_t        i_ctl,
    input  wire logic                        i_instr_done,
    // Pending and enabled requests, bit k is vector k+2
    input  wire logic [rvm_pkg::RVM_NUM_IRQ-1:0] i_irq_req,
    input  wire logic                        i_irq_ack,
    // Outputs to the core
    output logic [rvm_pkg::RVM_ADDR_W-1:0]   o_reset_addr,
    output rvm_pkg::rvm_vec_t                o_vec,
    output logic                             o_vector_table_select,
    output logic                             o_vector_change_enable,
    output logic                             o_irq_blocked
);
    import rvm_pkg::*;

    rvm_state_t                q_r;
    rvm_state_t                q_nxt;
    logic                      found;
    logic [RVM_NUM_W-1:0]      idx;
    logic                      sel_wr_ok;
    logic                      block_now;
    logic                      sel_nxt_tmp;
    logic [RVM_ADDR_W-1:0]     base_nxt;
    logic [RVM_NUM_W-1:0]      num_nxt;

    // ------------------------------------------------------------------
    // Request arbitration
    // ------------------------------------------------------------------
    // Lowest index wins, which is the lowest vector number
    rvm_prio_enc #(
        .N  (RVM_NUM_IRQ),
        .IW (RVM_NUM_W)
    ) u_prio (
        .i_req   (i_irq_req),
        .o_found (found),
        .o_idx   (idx)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;

        // Fuse straps are static but asynchronous, so two flops each
        q_nxt.fuse_m_r = i_boot_reset_fuse;
        q_nxt.fuse_s_r = q_r.fuse_m_r;
        q_nxt.boot_m_r = i_boot_start_addr;
        q_nxt.boot_s_r = q_r.boot_m_r;

        // Reset address follows only the fuse, never the select bit
        if (q_r.fuse_s_r == RVM_FUSE_UNPROG) begin
            q_nxt.rst_addr_r = RVM_APP_START;
        end else begin
            q_nxt.rst_addr_r = q_r.boot_s_r;
        end

        // A select write counts only while the change window is open
        sel_wr_ok = i_ctl.wr && !i_ctl.change_enable && q_r.ce_r
                    && (q_r.win_r != '0);

        // Change-enable, window counter and blocking state
        if (i_ctl.wr && i_ctl.change_enable) begin
            // Setting change-enable (again) reopens the full window
            q_nxt.ce_r  = 1'b1;
            q_nxt.win_r = RVM_CE_WINDOW;
            q_nxt.blk_r = RVM_BLK_ARMED;
        end else if (sel_wr_ok) begin
            q_nxt.sel_r = i_ctl.table_select;
            q_nxt.ce_r  = 1'b0;
            q_nxt.win_r = '0;
            q_nxt.blk_r = RVM_BLK_AFTER_WR;
        end else begin
            // Writes outside the window leave the select bit alone
            case (q_r.blk_r)
                RVM_BLK_ARMED: begin
                    q_nxt.win_r = q_r.win_r - 3'h1;
                    if (q_r.win_r <= 3'h1) begin
                        q_nxt.ce_r  = 1'b0;
                        q_nxt.blk_r = RVM_BLK_IDLE;
                    end
                end
                RVM_BLK_AFTER_WR: begin
                    // The next retire is the instruction after the write
                    if (i_instr_done) begin
                        q_nxt.blk_r = RVM_BLK_IDLE;
                    end
                end
                default: begin
                    q_nxt.blk_r = RVM_BLK_IDLE;
                end
            endcase
        end

        // Blocking does not touch any global enable, it only masks here
        block_now       = (q_nxt.blk_r != RVM_BLK_IDLE);
        q_nxt.blocked_r = block_now;

        // Vector base follows the select bit that will be in force
        sel_nxt_tmp = q_nxt.sel_r;
        base_nxt    = sel_nxt_tmp ? q_r.boot_s_r : RVM_APP_START;
        num_nxt     = idx + RVM_FIRST_IRQ;

        // Presentation: hold until taken, withdraw while blocked
        if (block_now) begin
            q_nxt.vec_r.valid = 1'b0;
        end else if (q_r.vec_r.valid && !i_irq_ack) begin
            q_nxt.vec_r = q_r.vec_r;
        end else if (q_r.vec_r.valid && i_irq_ack) begin
            // One idle cycle lets the core clear the served request
            q_nxt.vec_r.valid = 1'b0;
        end else if (found) begin
            q_nxt.vec_r.valid = 1'b1;
            q_nxt.vec_r.num   = num_nxt;
            // Table entry plus the relocation base
            q_nxt.vec_r.addr  = base_nxt
                + RVM_ADDR_W'(RVM_VEC_TAB[num_nxt - 5'h01]);
        end else begin
            q_nxt.vec_r.valid = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            q_r            <= '0;
            q_r.fuse_m_r   <= RVM_FUSE_UNPROG;
            q_r.fuse_s_r   <= RVM_FUSE_UNPROG;
            q_r.sel_r      <= RVM_SEL_RST;
            q_r.blk_r      <= RVM_BLK_IDLE;
            q_r.rst_addr_r <= RVM_APP_START;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    assign o_reset_addr           = q_r.rst_addr_r;
    assign o_vec                  = q_r.vec_r;
    assign o_vector_table_select  = q_r.sel_r;
    assign o_vector_change_enable = q_r.ce_r;
    assign o_irq_blocked          = q_r.blocked_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Helper: base in force and mask of sources below the presented one
    logic [RVM_ADDR_W-1:0]  chk_base;
    logic [RVM_ADDR_W-1:0]  chk_off;
    logic [RVM_NUM_IRQ-1:0] chk_low;

    always_comb begin
        chk_base = q_r.sel_r ? q_r.boot_s_r : RVM_APP_START;
        chk_off  = q_r.vec_r.addr - chk_base;
        chk_low  = '0;
        for (int k = 0; k < RVM_NUM_IRQ; k++) begin
            if (RVM_NUM_W'(k) + RVM_FIRST_IRQ < q_r.vec_r.num) begin
                chk_low[k] = 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    rst_app_a: assert property ($past(q_r.fuse_s_r) |-> o_reset_addr == 17'h00000)
        else $error("reset address not zero with fuse unprogrammed");
    rst_boot_a: assert property (!$past(q_r.fuse_s_r) |-> o_reset_addr == $past(q_r.boot_s_r))
        else $error("reset address not boot start with fuse programmed");
    fuse_decode_a: assert property (o_reset_addr != 17'h00000 |-> !$past(q_r.fuse_s_r))
        else $error("reset relocated without programmed fuse");
    vec_ext_a: assert property (o_vec.valid && o_vec.num == 5'h04 |-> chk_off == 17'h00006)
        else $error("external request 2 vector wrong");
    vec_wdt_a: assert property (o_vec.valid && o_vec.num == 5'h09 |-> chk_off == 17'h00010)
        else $error("watchdog vector wrong");
    vec_tmr2_a: assert property (o_vec.valid && o_vec.num == 5'h0C |-> chk_off == 17'h00016)
        else $error("second 8-bit timer overflow vector wrong");
    vec_tmr1_a: assert property (o_vec.valid && o_vec.num == 5'h0D |-> chk_off == 17'h00018)
        else $error("16-bit timer capture vector wrong");
    vec_tmr0_a: assert property (o_vec.valid && o_vec.num == 5'h13 |-> chk_off == 17'h00024)
        else $error("first 8-bit timer overflow vector wrong");
    vec_spi_a: assert property (o_vec.valid && o_vec.num == 5'h14 |-> chk_off == 17'h00026)
        else $error("serial peripheral vector wrong");
    vec_uart0_a: assert property (o_vec.valid && o_vec.num == 5'h15 |-> chk_off == 17'h00028)
        else $error("first serial port receive vector wrong");
    vec_store_a: assert property (o_vec.valid && o_vec.num == 5'h1C |-> chk_off == 17'h00036)
        else $error("store ready vector wrong");
    vec_uart1_a: assert property (o_vec.valid && o_vec.num == 5'h1F |-> chk_off == 17'h0003C)
        else $error("second serial port transmit vector wrong");
    vec_reloc_a: assert property (o_vec.valid && o_vector_table_select
        |-> o_vec.addr == q_r.boot_s_r + RVM_ADDR_W'(2 * (o_vec.num - 5'h01)))
        else $error("relocated vector not offset by boot start");
    sel_indep_a: assert property ($changed(o_vector_table_select) |-> $stable(o_reset_addr))
        else $error("reset address moved with table select");
    vec_space_a: assert property (o_vec.valid |-> chk_off == RVM_ADDR_W'(2 * (o_vec.num - 5'h01)))
        else $error("vectors not two words apart");
    sel_guard_a: assert property ($changed(o_vector_table_select)
        |-> $past(i_ctl.wr && !i_ctl.change_enable && q_r.ce_r))
        else $error("select changed outside the change window");
    ce_timeout_a: assert property ($rose(o_vector_change_enable)
        |-> ##[1:4] !o_vector_change_enable)
        else $error("change window open longer than four cycles");
    blk_hold_a: assert property ($rose(o_vector_change_enable)
        |-> o_irq_blocked && !o_vec.valid ##1 o_irq_blocked)
        else $error("interrupts not blocked after change enable");
    blk_mask_a: assert property (o_irq_blocked |-> !o_vec.valid)
        else $error("vector presented while blocked");
    prio_low_a: assert property ($rose(o_vec.valid) |-> ($past(i_irq_req) & chk_low) == '0)
        else $error("lower vector number was pending but not served");

    cov_serve_c:  cover property (o_vec.valid && i_irq_ack);
    cov_reloc_c:  cover property (o_vec.valid && o_vector_table_select);
    cov_change_c: cover property ($changed(o_vector_table_select));
    cov_expire_c: cover property ($fell(o_vector_change_enable) && !$changed(o_vector_table_select));

endmodule : rvm_vector_map

`default_nettype wire

// *** sim/rvm_core_model.sv ***
// Behavioural core that takes presented vectors after a chosen delay
`timescale 1ns/100ps
`default_nettype none

module rvm_core_model (
    // Clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    // Vector from the map and the wanted acknowledge delay
    input  wire rvm_pkg::rvm_vec_t i_vec,
    input  wire logic [3:0]        i_ack_delay,
    // Acknowledge and record of the last vector taken
    output logic                   o_irq_ack,
    output logic [4:0]             o_taken_num,
    output logic [16:0]            o_taken_addr,
    output int unsigned            o_taken_cnt
);
    import rvm_pkg::*;

    logic [3:0] wait_r;

    // ------------------------------------------------------------------
    // Acknowledge driver
    // ------------------------------------------------------------------
    // Drives off the falling edge so the acknowledge is stable at the sampling edge
    always @(negedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_irq_ack <= 1'b0;
            wait_r    <= 4'h0;
        end else if (o_irq_ack) begin
            o_irq_ack <= 1'b0;
            wait_r    <= 4'h0;
        end else if (i_vec.valid) begin
            o_irq_ack <= (wait_r == i_ack_delay);
            wait_r    <= wait_r + 4'h1;
        end else begin
            wait_r    <= 4'h0;    // Withdrawn vector restarts the wait
        end
    end

    // Record only what the map really handed over at the sampling edge
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_taken_num  <= 5'h00;
            o_taken_addr <= 17'h00000;
            o_taken_cnt  <= 0;
        end else if (o_irq_ack && i_vec.valid) begin
            o_taken_num  <= i_vec.num;
            o_taken_addr <= i_vec.addr;
            o_taken_cnt  <= o_taken_cnt + 1;
        end
    end

endmodule : rvm_core_model
`default_nettype wire

// *** sim/rvm_vector_map_tb.sv ***
// Self-checking testbench of the reset and interrupt vector map
`timescale 1ns/100ps
`default_nettype none

module rvm_vector_map_tb;
    import rvm_pkg::*;

    localparam logic [16:0] BOOT = 17'h1F000;

    logic        i_clk_sys = 1'b0;
    logic        i_rst     = 1'b1;
    logic        fuse      = 1'b1;
    logic [16:0] boot      = BOOT;
    rvm_ctl_wr_t ctl       = '0;
    logic        instr_done = 1'b0;
    logic [29:0] req       = '0;
    logic [3:0]  ack_dly   = 4'h0;
    logic        ack;
    logic [16:0] rst_addr;
    rvm_vec_t    vec;
    logic        sel;
    logic        ce;
    logic        blocked;
    logic [4:0]  t_num;
    logic [16:0] t_addr;
    int unsigned t_cnt;
    int          err_total    = 0;
    int          total_checks = 0;

    always #10 i_clk_sys = ~i_clk_sys;

    rvm_vector_map dut (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_boot_reset_fuse(fuse),
        .i_boot_start_addr(boot), .i_ctl(ctl), .i_instr_done(instr_done),
        .i_irq_req(req), .i_irq_ack(ack), .o_reset_addr(rst_addr), .o_vec(vec),
        .o_vector_table_select(sel), .o_vector_change_enable(ce),
        .o_irq_blocked(blocked));

    rvm_core_model core (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_vec(vec), .i_ack_delay(ack_dly),
        .o_irq_ack(ack), .o_taken_num(t_num), .o_taken_addr(t_addr),
        .o_taken_cnt(t_cnt));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // Reset held four cycles, then three edges for the fuse synchroniser
    task automatic do_reset;
        @(negedge i_clk_sys) i_rst = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        i_rst = 1'b0;
        repeat (3) @(negedge i_clk_sys);
    endtask : do_reset

    // One-cycle control write; returns half a cycle after the write edge, at the next falling edge
    task automatic ctl_wr(input logic c_en, input logic t_sel);
        @(negedge i_clk_sys) ctl = '{wr: 1'b1, change_enable: c_en, table_select: t_sel};
        @(negedge i_clk_sys) ctl = '0;
    endtask : ctl_wr

    // Waits a bounded time for the core to take a vector, then compares it
    task automatic take(input logic [4:0] num, input logic [16:0] addr);
        int unsigned n;
        n = t_cnt;
        for (int i = 0; i < 40 && t_cnt == n; i++) @(negedge i_clk_sys);
        chk("taken count", n + 1, t_cnt);
        chk("vector number", {27'h0, num}, {27'h0, t_num});
        chk("vector address", {15'h0, addr}, {15'h0, t_addr});
    endtask : take

    task automatic pulse_done;
        @(negedge i_clk_sys) instr_done = 1'b1;
        @(negedge i_clk_sys) instr_done = 1'b0;
    endtask : pulse_done

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Programmed fuse moves reset but leaves the table in application space
    task automatic t_reset;
        chk("reset address", 32'h0, {15'h0, rst_addr});
        fuse = 1'b0;
        do_reset();
        chk("boot reset address", {15'h0, BOOT}, {15'h0, rst_addr});
        req = 30'h1;
        take(5'h02, 17'h00002);
        req = '0;
        fuse = 1'b1;
        do_reset();
        chk("reset address again", 32'h0, {15'h0, rst_addr});
        $display("test reset done");
    endtask : t_reset

    // Every source alone, with prompt and slow acknowledges
    task automatic t_map;
        for (int k = 0; k < 30; k++) begin
            ack_dly = 4'(k % 3);
            req = 30'h1 << k;
            take(5'(k + 2), 17'(2 * (k + 1)));
            req = '0;
            // Let an edge pass so the next source is a fresh request
            @(negedge i_clk_sys);
        end
        ack_dly = 4'h0;
        $display("test map done");
    endtask : t_map

    // Three pending together are served lowest vector number first
    task automatic t_prio;
        req = 30'h20000009;
        take(5'h02, 17'h00002);
        req[0] = 1'b0;
        take(5'h05, 17'h00008);
        req[3] = 1'b0;
        take(5'h1F, 17'h0003C);
        req = '0;
        $display("test priority done");
    endtask : t_prio

    // Timed sequence moves the table to the boot section
    task automatic t_reloc;
        ctl_wr(1'b1, 1'b0);
        chk("change enable", 32'h1, {31'h0, ce});
        chk("blocked", 32'h1, {31'h0, blocked});
        ctl_wr(1'b0, 1'b1);
        req = 30'h1 << 26;
        chk("select", 32'h1, {31'h0, sel});
        chk("change enable closed", 32'h0, {31'h0, ce});
        @(negedge i_clk_sys);
        chk("held while blocked", 32'h0, {31'h0, vec.valid});
        pulse_done();
        chk("unblocked", 32'h0, {31'h0, blocked});
        take(5'h1C, BOOT + 17'h00036);
        req = '0;
        chk("reset address kept", 32'h0, {15'h0, rst_addr});
        $display("test relocation done");
    endtask : t_reloc

    // Stray writes are ignored and an unused window blocks four cycles
    task automatic t_refuse;
        ctl_wr(1'b0, 1'b0);
        chk("select after stray write", 32'h1, {31'h0, sel});
        ack_dly = 4'hF;
        req = 30'h2;
        ctl_wr(1'b1, 1'b1);
        for (int c = 1; c <= 4; c++) begin
            chk("window open", 32'h1, {31'h0, ce});
            chk("window blocked", 32'h1, {31'h0, blocked});
            chk("nothing presented", 32'h0, {31'h0, vec.valid});
            @(negedge i_clk_sys);
        end
        chk("window closed", 32'h0, {31'h0, ce});
        chk("block released", 32'h0, {31'h0, blocked});
        chk("select unchanged", 32'h1, {31'h0, sel});
        take(5'h03, BOOT + 17'h00004);
        req = '0;
        ack_dly = 4'h0;
        ctl_wr(1'b0, 1'b0);
        chk("late write ignored", 32'h1, {31'h0, sel});
        ctl_wr(1'b1, 1'b1);
        ctl_wr(1'b0, 1'b0);
        chk("select cleared", 32'h0, {31'h0, sel});
        pulse_done();
        req = 30'h1 << 29;
        take(5'h1F, 17'h0003C);
        req = '0;
        $display("test refusal done");
    endtask : t_refuse

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        do_reset();
        t_reset();
        t_map();
        t_prio();
        t_reloc();
        t_refuse();
        end_sim();
    end

    // Whole run needs under two thousand cycles; ten times that means a hang
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_total++;
        end_sim();
    end

endmodule : rvm_vector_map_tb
`default_nettype wire
